// file: inc/audio_ctl_consts.svh
// Register offsets, field positions, reset values and decode limits
`ifndef AUDIO_CTL_CONSTS_SVH
`define AUDIO_CTL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets on the control write port
// ----------------------------------------------------------------------
`define ADDR_MUTE_OVR     8'h01
`define ADDR_POWER        8'h03
`define ADDR_VOLUME       8'h10
`define ADDR_TONE         8'h12

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_MUTE_OVR      8
`define MUTE_MUST_HI      2
`define MUTE_MUST_LO      0
`define BIT_SLICER_PON    4
`define PWR_MUST_HI       3
`define PWR_MUST_LO       2
`define BIT_INTERP_CLK    1
`define BIT_CONV_PON      0
`define VOL_LEFT_HI       15
`define VOL_LEFT_LO       8
`define VOL_RIGHT_HI      7
`define VOL_RIGHT_LO      0
`define TONE_SET_HI       15
`define TONE_SET_LO       14
`define TONE_TREBLE_HI    13
`define TONE_TREBLE_LO    12
`define TONE_BASS_HI      11
`define TONE_BASS_LO      8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_MUTE_OVR      1'h0
`define RST_SLICER_PON    1'h1
`define RST_INTERP_CLK    1'h1
`define RST_CONV_PON      1'h1
`define RST_VOL_CODE      8'h00
`define RST_TREBLE        2'h0
`define RST_BASS          4'h0

// ----------------------------------------------------------------------
// Volume code regions (attenuation in quarter dB)
// ----------------------------------------------------------------------
`define VOL_FINE_LAST     8'hC7
`define VOL_COARSE_LAST   8'hF3
`define VOL_FLOOR_LAST    8'hF7
`define VOL_COARSE_MASK   8'hFC
`define ATTEN_FLOOR_QDB   9'h108

// ----------------------------------------------------------------------
// Tone limits (dB)
// ----------------------------------------------------------------------
`define BASS_CAP_MIN      5'h12
`define BASS_CAP_MAX      5'h18

`endif

// file: inc/audio_ctl_pkg.sv
// Types shared by the control register bank and its decoders
package audio_ctl_pkg;

  // Filter set selected by the mode field
  typedef enum logic [1:0] {
    SET_FLAT   = 2'b00,
    SET_MIN    = 2'b01,
    SET_UNUSED = 2'b10,
    SET_MAX    = 2'b11
  } filter_set_t;

  // Decoded channel attenuation
  typedef struct packed {
    logic       silent;
    logic [8:0] qdb;
  } atten_t;

endpackage

// file: inc/ctl_if.sv
// Carrier between the register bank and its two decoders
`timescale 1ns/10ps
interface ctl_if
  import audio_ctl_pkg::*;
();
  logic        [1:0][7:0] vol_code;
  atten_t      [1:0]      vol_att;
  filter_set_t            set_sel;
  logic        [1:0]      treble;
  logic        [3:0]      bass;
  logic        [3:0]      treble_db;
  logic        [4:0]      bass_db;

  modport regs (output vol_code, output set_sel, output treble,
                output bass, input vol_att, input treble_db,
                input bass_db);
  modport vol  (input vol_code, output vol_att);
  modport tone (input set_sel, input treble, input bass,
                output treble_db, output bass_db);
endinterface

// file: hw/vol_decode.sv
// Volume code to attenuation decoder for both channels
`timescale 1ns/10ps
`include "audio_ctl_consts.svh"
module vol_decode
  import audio_ctl_pkg::*;
(
  // Codes in, attenuation out
  ctl_if.vol c
);

  // ----------------------------------------------------------------------
  // Code to quarter-dB map
  // ----------------------------------------------------------------------
  function automatic atten_t decode_vol(input logic [7:0] code);
    atten_t a;
    a.silent = 1'b0;
    a.qdb    = 9'h000;
    if (code <= `VOL_FINE_LAST) begin
      a.qdb = {1'b0, code};
    end else if (code <= `VOL_COARSE_LAST) begin
      // Clearing the low bits falls back to the lighter step
      a.qdb = {1'b0, code & `VOL_COARSE_MASK};
    end else if (code <= `VOL_FLOOR_LAST) begin
      a.qdb = `ATTEN_FLOOR_QDB;
    end else begin
      a.silent = 1'b1;
      a.qdb    = `ATTEN_FLOOR_QDB;
    end
    return a;
  endfunction

  // ----------------------------------------------------------------------
  // One decoder per channel
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign c.vol_att[ch] = decode_vol(c.vol_code[ch]);
    end
  endgenerate

endmodule

// file: hw/tone_decode.sv
// Treble and bass boost level decoder for the selected filter set
`timescale 1ns/10ps
`include "audio_ctl_consts.svh"
module tone_decode
  import audio_ctl_pkg::*;
(
  // Fields in, levels in dB out
  ctl_if.tone c
);

  // ----------------------------------------------------------------------
  // Level lookup
  // ----------------------------------------------------------------------
  logic [4:0] raw_bass;

  // Unused mode code behaves as the flat set
  always_comb begin
    raw_bass    = {c.bass, 1'b0};
    c.treble_db = 4'h0;
    c.bass_db   = 5'h00;
    case (c.set_sel)
      SET_MIN: begin
        c.treble_db = {1'b0, c.treble, 1'b0};
        c.bass_db   = (raw_bass > `BASS_CAP_MIN) ?
                      `BASS_CAP_MIN : raw_bass;
      end
      SET_MAX: begin
        c.treble_db = {1'b0, c.treble, 1'b0};
        c.bass_db   = (raw_bass > `BASS_CAP_MAX) ?
                      `BASS_CAP_MAX : raw_bass;
      end
      default: begin
        c.treble_db = 4'h0;
        c.bass_db   = 5'h00;
      end
    endcase
  end

endmodule

// file: hw/audio_dac_ctl.sv
// Write-only control register bank of the audio converter
`timescale 1ns/10ps
`include "audio_ctl_consts.svh"
module audio_dac_ctl
  import audio_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register write port from the serial control decoder
  input  wire logic              wr_valid,
  input  wire logic [7:0]        wr_addr,
  input  wire logic [15:0]       wr_data,
  output logic                   wr_ack_q,
  output logic                   host_field_err_q,
  // Receiver state from the input path
  input  wire logic              rx_locked,
  input  wire logic              rx_non_pcm,
  // Mute and power controls
  output logic                   unlock_mute_override,
  output logic                   audio_mute_q,
  output logic                   slicer_power_on,
  output logic                   interp_clk_en,
  output logic                   converter_power_on,
  // Volume
  output logic [7:0]             left_attenuation_code,
  output logic [7:0]             right_attenuation_code,
  output atten_t                 left_atten_q,
  output atten_t                 right_atten_q,
  // Tone
  output filter_set_t            filter_set_q,
  output logic [1:0]             treble_level,
  output logic [3:0]             bass_boost_level,
  output logic [3:0]             treble_db_q,
  output logic [4:0]             bass_db_q
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic        mute_ovr_q,   mute_ovr_d;
  logic        slicer_q,     slicer_d;
  logic        interp_q,     interp_d;
  logic        conv_q,       conv_d;
  logic [7:0]  left_q,       left_d;
  logic [7:0]  right_q,      right_d;
  filter_set_t set_q,        set_d;
  logic [1:0]  treble_q,     treble_d;
  logic [3:0]  bass_q,       bass_d;

  // ----------------------------------------------------------------------
  // Address decode, used for both the write and the acknowledge
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic       v,
                               input logic [7:0] a,
                               input logic [7:0] off);
    return v && (a == off);
  endfunction

  logic sel_mute;
  logic sel_pwr;
  logic sel_vol;
  logic sel_tone;

  // Per-register select strobes
  assign sel_mute = hit(wr_valid, wr_addr, `ADDR_MUTE_OVR);
  assign sel_pwr  = hit(wr_valid, wr_addr, `ADDR_POWER);
  assign sel_vol  = hit(wr_valid, wr_addr, `ADDR_VOLUME);
  assign sel_tone = hit(wr_valid, wr_addr, `ADDR_TONE);

  // ----------------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------------
  // Only named fields are taken; reserved bits fall on the floor
  always_comb begin
    mute_ovr_d = mute_ovr_q;
    slicer_d   = slicer_q;
    interp_d   = interp_q;
    conv_d     = conv_q;
    left_d     = left_q;
    right_d    = right_q;
    set_d      = set_q;
    treble_d   = treble_q;
    bass_d     = bass_q;
    if (sel_mute) begin
      mute_ovr_d = wr_data[`BIT_MUTE_OVR];
    end
    if (sel_pwr) begin
      slicer_d = wr_data[`BIT_SLICER_PON];
      interp_d = wr_data[`BIT_INTERP_CLK];
      conv_d   = wr_data[`BIT_CONV_PON];
    end
    if (sel_vol) begin
      left_d  = wr_data[`VOL_LEFT_HI:`VOL_LEFT_LO];
      right_d = wr_data[`VOL_RIGHT_HI:`VOL_RIGHT_LO];
    end
    if (sel_tone) begin
      set_d    = filter_set_t'(wr_data[`TONE_SET_HI:`TONE_SET_LO]);
      treble_d = wr_data[`TONE_TREBLE_HI:`TONE_TREBLE_LO];
      bass_d   = wr_data[`TONE_BASS_HI:`TONE_BASS_LO];
    end
  end

  // Registers change only on writes and reset; nothing reads them back
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mute_ovr_q <= `RST_MUTE_OVR;
      slicer_q   <= `RST_SLICER_PON;
      interp_q   <= `RST_INTERP_CLK;
      conv_q     <= `RST_CONV_PON;
      left_q     <= `RST_VOL_CODE;
      right_q    <= `RST_VOL_CODE;
      set_q      <= SET_FLAT;
      treble_q   <= `RST_TREBLE;
      bass_q     <= `RST_BASS;
    end else begin
      mute_ovr_q <= mute_ovr_d;
      slicer_q   <= slicer_d;
      interp_q   <= interp_d;
      conv_q     <= conv_d;
      left_q     <= left_d;
      right_q    <= right_d;
      set_q      <= set_d;
      treble_q   <= treble_d;
      bass_q     <= bass_d;
    end
  end

  // Raw fields straight from their flops
  assign unlock_mute_override   = mute_ovr_q;
  assign slicer_power_on        = slicer_q;
  assign interp_clk_en          = interp_q;
  assign converter_power_on     = conv_q;
  assign left_attenuation_code  = left_q;
  assign right_attenuation_code = right_q;
  assign treble_level           = treble_q;
  assign bass_boost_level       = bass_q;

  // ----------------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------------
  ctl_if c ();

  // Channel 1 is left, channel 0 is right
  assign c.vol_code[1] = left_q;
  assign c.vol_code[0] = right_q;
  assign c.set_sel     = set_q;
  assign c.treble      = treble_q;
  assign c.bass        = bass_q;

  vol_decode u_vol (
    .c (c.vol)
  );

  tone_decode u_tone (
    .c (c.tone)
  );

  // ----------------------------------------------------------------------
  // Mute and decoded level outputs
  // ----------------------------------------------------------------------
  logic        mute_d;
  atten_t      left_att_d;
  atten_t      right_att_d;
  logic [3:0]  treble_db_d;
  logic [4:0]  bass_db_d;

  // Receiver inputs are on this clock, so no synchroniser is needed
  always_comb begin
    mute_d      = !mute_ovr_q && (!rx_locked || rx_non_pcm);
    left_att_d  = c.vol_att[1];
    right_att_d = c.vol_att[0];
    treble_db_d = c.treble_db;
    bass_db_d   = c.bass_db;
  end

  // Decoded levels trail the register by one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      audio_mute_q  <= 1'b1;
      left_atten_q  <= '0;
      right_atten_q <= '0;
      filter_set_q  <= SET_FLAT;
      treble_db_q   <= 4'h0;
      bass_db_q     <= 5'h00;
    end else begin
      audio_mute_q  <= mute_d;
      left_atten_q  <= left_att_d;
      right_atten_q <= right_att_d;
      filter_set_q  <= set_q;
      treble_db_q   <= treble_db_d;
      bass_db_q     <= bass_db_d;
    end
  end

  // ----------------------------------------------------------------------
  // Write acknowledge and host field check
  // ----------------------------------------------------------------------
  logic ack_d;
  logic field_err_d;

  // Sticky until reset so a bad host driver is visible later
  always_comb begin
    ack_d       = sel_mute || sel_pwr || sel_vol || sel_tone;
    field_err_d = host_field_err_q;
    if (sel_mute &&
        (wr_data[`MUTE_MUST_HI:`MUTE_MUST_LO] != 3'h0)) begin
      field_err_d = 1'b1;
    end
    if (sel_pwr &&
        (wr_data[`PWR_MUST_HI:`PWR_MUST_LO] != 2'h0)) begin
      field_err_d = 1'b1;
    end
  end

  // Acknowledge pulses one cycle after a mapped write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ack_q         <= 1'b0;
      host_field_err_q <= 1'b0;
    end else begin
      wr_ack_q         <= ack_d;
      host_field_err_q <= field_err_d;
    end
  end

endmodule

// file: tb/audio_dac_ctl_properties.sv
// Port-level checker for the control register bank
`timescale 1ns/10ps
`include "audio_ctl_consts.svh"
module audio_dac_ctl_checker
  import audio_ctl_pkg::*;
(
  // Clock, reset and write port
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wr_valid,
  input wire logic [7:0]  wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_ack_q,
  input wire logic        host_field_err_q,
  // Receiver state and controls
  input wire logic        rx_locked,
  input wire logic        rx_non_pcm,
  input wire logic        unlock_mute_override,
  input wire logic        audio_mute_q,
  input wire logic        slicer_power_on,
  input wire logic        interp_clk_en,
  input wire logic        converter_power_on,
  // Volume and tone
  input wire logic [7:0]  left_attenuation_code,
  input wire logic [7:0]  right_attenuation_code,
  input wire atten_t      left_atten_q,
  input wire atten_t      right_atten_q,
  input wire filter_set_t filter_set_q,
  input wire logic [3:0]  treble_db_q,
  input wire logic [4:0]  bass_db_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Write hits one of the four decoded offsets
  wire hit = wr_valid && (wr_addr inside {`ADDR_MUTE_OVR, `ADDR_POWER,
                                          `ADDR_VOLUME, `ADDR_TONE});

  AST_ACK: assert property (hit |=> wr_ack_q)
    else $error("mapped write not acknowledged");
  AST_NOACK: assert property (!hit |=> !wr_ack_q)
    else $error("acknowledge without a mapped write");
  AST_MUTE: assert property (1'b1 |=> audio_mute_q ==
    (!$past(unlock_mute_override) && (!$past(rx_locked) || $past(rx_non_pcm))))
    else $error("mute output disagrees with lock and override");
  AST_OVR: assert property (wr_valid && wr_addr == `ADDR_MUTE_OVR
    |=> unlock_mute_override == $past(wr_data[8]))
    else $error("override bit not taken from bit 8");
  AST_PWR: assert property (wr_valid && wr_addr == `ADDR_POWER
    |=> {slicer_power_on, interp_clk_en, converter_power_on} ==
        {$past(wr_data[4]), $past(wr_data[1]), $past(wr_data[0])})
    else $error("power controls not taken from bits 4, 1, 0");
  AST_VOL: assert property (wr_valid && wr_addr == `ADDR_VOLUME
    |=> {left_attenuation_code, right_attenuation_code} == $past(wr_data))
    else $error("volume codes not taken from the write");
  AST_HOLD: assert property (!(wr_valid && wr_addr == `ADDR_VOLUME)
    |=> $stable(left_attenuation_code))
    else $error("left code moved without a volume write");
  AST_TONE: assert property (wr_valid && wr_addr == `ADDR_TONE
    |-> ##2 filter_set_q == $past(wr_data[15:14], 2))
    else $error("filter set not taken from bits 15..14");
  AST_FINE: assert property (left_attenuation_code <= 8'hC7
    |=> left_atten_q == {2'b00, $past(left_attenuation_code)})
    else $error("fine region not a quarter dB per code");
  AST_COARSE: assert property (right_attenuation_code inside {[8'hC8:8'hF3]}
    |=> right_atten_q == {2'b00, $past(right_attenuation_code) & 8'hFC})
    else $error("coarse region not a whole dB per four codes");
  AST_SILENT: assert property (left_attenuation_code >= 8'hF8
    |=> left_atten_q.silent)
    else $error("top codes do not silence the channel");
  AST_FLAT: assert property (filter_set_q == SET_FLAT
    |-> treble_db_q == 4'h0 && bass_db_q == 5'h00)
    else $error("flat set gives a nonzero tone level");
  AST_ERR: assert property ((host_field_err_q || (wr_valid &&
    wr_addr == `ADDR_POWER && wr_data[3:2] != 2'h0)) |=> host_field_err_q)
    else $error("field error flag not raised or not held");
endmodule

bind audio_dac_ctl audio_dac_ctl_checker checker_inst (
  .clk_sys(clk_sys), .rst(rst), .wr_valid(wr_valid), .wr_addr(wr_addr),
  .wr_data(wr_data), .wr_ack_q(wr_ack_q),
  .host_field_err_q(host_field_err_q), .rx_locked(rx_locked),
  .rx_non_pcm(rx_non_pcm), .unlock_mute_override(unlock_mute_override),
  .audio_mute_q(audio_mute_q), .slicer_power_on(slicer_power_on),
  .interp_clk_en(interp_clk_en), .converter_power_on(converter_power_on),
  .left_attenuation_code(left_attenuation_code),
  .right_attenuation_code(right_attenuation_code),
  .left_atten_q(left_atten_q), .right_atten_q(right_atten_q),
  .filter_set_q(filter_set_q), .treble_db_q(treble_db_q),
  .bass_db_q(bass_db_q));

// file: tb/host_model.sv
// Behavioural host issuing register writes to the bank
`timescale 1ns/10ps
`include "audio_ctl_consts.svh"
module host_model (
  // Clock
  input  wire logic   clk_sys,
  // Write port towards the bank
  output logic        wr_valid,
  output logic [7:0]  wr_addr,
  output logic [15:0] wr_data
);
  // Idle bus at time zero
  initial begin
    wr_valid = 1'b0;
    wr_addr  = 8'h00;
    wr_data  = 16'h0000;
  end

  // One-cycle write pulse, launched and released at falling edges
  task automatic write(input logic [7:0] a, input logic [15:0] d,
                       input logic raw);
    logic [15:0] v;
    v = d;
    if (!raw && a == `ADDR_MUTE_OVR) v[2:0] = 3'h0;
    if (!raw && a == `ADDR_POWER) v[3:2] = 2'h0;
    @(negedge clk_sys);
    wr_valid <= 1'b1;
    wr_addr  <= a;
    wr_data  <= v;
    @(negedge clk_sys);
    // Inverted leftovers, so a stale value can never pass for fresh
    wr_valid <= 1'b0;
    wr_addr  <= ~a;
    wr_data  <= ~v;
  endtask
endmodule

// file: tb/audio_dac_ctl_test.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
`include "audio_ctl_consts.svh"
module audio_dac_ctl_test
  import audio_ctl_pkg::*;
();
  logic        clk_sys, rst, wr_valid, wr_ack_q, host_field_err_q;
  logic        rx_locked, rx_non_pcm, unlock_mute_override, audio_mute_q;
  logic        slicer_power_on, interp_clk_en, converter_power_on;
  logic [7:0]  wr_addr, left_attenuation_code, right_attenuation_code;
  logic [15:0] wr_data, e_vol, e_tone;
  atten_t      left_atten_q, right_atten_q;
  filter_set_t filter_set_q;
  logic [1:0]  treble_level;
  logic [3:0]  bass_boost_level, treble_db_q;
  logic [4:0]  bass_db_q;
  logic        e_ovr;
  logic [2:0]  e_pwr;
  logic [56:0] notes[$];
  int          fail_count, compares, i, k;
  int          seed = 32'h8ACA;
  logic [7:0]  codes[14] = '{8'h00, 8'h01, 8'h02, 8'hC7, 8'hC8, 8'hC9,
                 8'hCB, 8'hCC, 8'hF0, 8'hF3, 8'hF4, 8'hF7, 8'hF8, 8'hFF};
  // Raw fields in the upper part, decoded levels below
  wire  [56:0] seen = {unlock_mute_override, slicer_power_on, interp_clk_en,
    converter_power_on, left_attenuation_code, right_attenuation_code,
    treble_level, bass_boost_level, left_atten_q, right_atten_q,
    filter_set_q, treble_db_q, bass_db_q};

  audio_dac_ctl audio_dac_ctl_inst (.clk_sys(clk_sys), .rst(rst),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ack_q(wr_ack_q), .host_field_err_q(host_field_err_q),
    .rx_locked(rx_locked), .rx_non_pcm(rx_non_pcm),
    .unlock_mute_override(unlock_mute_override), .audio_mute_q(audio_mute_q),
    .slicer_power_on(slicer_power_on), .interp_clk_en(interp_clk_en),
    .converter_power_on(converter_power_on),
    .left_attenuation_code(left_attenuation_code),
    .right_attenuation_code(right_attenuation_code),
    .left_atten_q(left_atten_q), .right_atten_q(right_atten_q),
    .filter_set_q(filter_set_q), .treble_level(treble_level),
    .bass_boost_level(bass_boost_level), .treble_db_q(treble_db_q),
    .bass_db_q(bass_db_q));
  host_model host_model_inst (.clk_sys(clk_sys), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data));

  // --------------------------------------------------------------------
  // Expected values
  // --------------------------------------------------------------------
  function automatic logic [9:0] att(input logic [7:0] c);
    if (c >= 8'hF8) return {1'b1, 9'h108};
    if (c >= 8'hF4) return {1'b0, 9'h108};
    if (c >= 8'hC8) return {2'b00, c & 8'hFC};
    return {2'b00, c};
  endfunction

  // Treble then bass in dB; mode 10 falls back to flat
  function automatic logic [8:0] tone_db(input logic [15:0] t);
    logic [4:0] cap;
    logic [4:0] b;
    cap = t[15] ? 5'h18 : 5'h12;
    b = {t[11:8], 1'b0};
    if (!t[14]) return 9'h000;
    return {1'b0, t[13:12], 1'b0, (b > cap) ? cap : b};
  endfunction

  function automatic logic [56:0] expect_all();
    return {e_ovr, e_pwr, e_vol, e_tone[13:8], att(e_vol[15:8]),
            att(e_vol[7:0]), e_tone[15:14], tone_db(e_tone)};
  endfunction

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [56:0] got, input logic [56:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Update the field model, note the result, then send the write
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic raw);
    logic hit;
    hit = 1'b1;
    case (a)
      `ADDR_MUTE_OVR: e_ovr = d[8];
      `ADDR_POWER:    e_pwr = {d[4], d[1:0]};
      `ADDR_VOLUME:   e_vol = d;
      `ADDR_TONE:     e_tone = d;
      default:        hit = 1'b0;
    endcase
    if (hit) notes.push_back(expect_all());
    host_model_inst.write(a, d, raw);
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic reset_all();
    rst = 1'b1;
    e_ovr = 1'b0;
    e_pwr = 3'h7;
    e_vol = 16'h0000;
    e_tone = 16'h0000;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    check(seen, expect_all());
    check(57'(host_field_err_q), 57'h0);
  endtask

  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(negedge clk_sys);
    fail_count++;
    summarize();
  end

  // Watcher: each acknowledge takes the oldest note
  initial begin
    logic [56:0] e;
    forever begin
      @(negedge clk_sys);
      if (wr_ack_q === 1'b1) begin
        if (notes.size() == 0) begin
          check(57'h0, 57'h1);
        end else begin
          e = notes.pop_front();
          check({seen[56:31], e[30:0]}, e);
          @(negedge clk_sys);
          check({e[56:31], seen[30:0]}, e);
        end
      end
    end
  end

  // Main sequence
  initial begin
    fail_count = 0;
    compares = 0;
    rx_locked = 1'b1;
    rx_non_pcm = 1'b0;
    reset_all();
    for (i = 0; i < 8; i++) begin
      wr(`ADDR_POWER, (16'($random(seed)) & 16'hFFEC) | 16'(i * 5), 0);
    end
    for (k = 0; k < 14; k++) begin
      wr(`ADDR_VOLUME, {codes[k], codes[13 - k]}, 0);
    end
    for (k = 0; k < 16; k++) begin
      wr(`ADDR_VOLUME, 16'($random(seed)), 0);
    end
    for (i = 0; i < 64; i++) begin
      // Mode and bass from the loop index, treble and reserved bits random
      wr(`ADDR_TONE, {i[5:4], 14'h0000} | {4'h0, i[3:0], 8'h00} |
         (16'($random(seed)) & 16'h30FF), 0);
    end
    for (i = 0; i < 8; i++) begin
      wr(`ADDR_MUTE_OVR, (16'($random(seed)) & 16'hFEFF) |
         {7'h00, i[2], 8'h00}, 0);
      rx_locked = i[1];
      rx_non_pcm = i[0];
      repeat (2) @(negedge clk_sys);
      check(57'(audio_mute_q), 57'(!i[2] && (!i[1] || i[0])));
    end
    wr(8'h13, 16'($random(seed)), 0);
    wr(8'h7F, 16'($random(seed)), 0);
    check(seen, expect_all());
    check(57'(host_field_err_q), 57'h0);
    wr(`ADDR_POWER, 16'h000C, 1);
    wr(`ADDR_POWER, 16'h0013, 0);
    check(57'(host_field_err_q), 57'h1);
    reset_all();
    // Must-be-zero bits of the override register raise the flag too
    wr(`ADDR_MUTE_OVR, 16'h0105, 1);
    check(57'(host_field_err_q), 57'h1);
    for (k = 0; k < 10 && notes.size() > 0; k++) @(negedge clk_sys);
    if (notes.size() > 0) fail_count++;
    summarize();
  end
endmodule
